// ==== verilog/ipm_defs.svh ====
`ifndef IPM_DEFS_SVH
`define IPM_DEFS_SVH
// register offsets
`define IPM_OFS_IEN_FIRST   8'ha8
`define IPM_OFS_IEN_SECOND  8'he8
`define IPM_OFS_PRIO_HI_A   8'hb7
`define IPM_OFS_PRIO_LO_A   8'hb8
`define IPM_OFS_PRIO_HI_B   8'hf7
`define IPM_OFS_PRIO_LO_B   8'hf8
`define IPM_OFS_PWR_CTRL    8'h87
`define IPM_OFS_STATUS      8'h90
// field positions
`define IPM_BIT_GLOBAL_EN   7
`define IPM_BIT_BROWNOUT_EN 3
`define IPM_BIT_BROWNOUT_PR 4
`define IPM_BIT_IDLE        0
`define IPM_BIT_PDOWN       1
// writable masks, reserved bits read as zero
`define IPM_MASK_PRIO_A     8'h7f
`define IPM_MASK_SECOND     8'h08
`define IPM_MASK_PRIO_B     8'h10
`define IPM_MASK_PWR        8'h03
// reset values
`define IPM_RST_REG         8'h00
// wake hold time in oscillator cycles
`define IPM_WAKE_HOLD_CYC   1024
`endif

// ==== verilog/ipm_pkg.sv ====
package ipm_pkg;
    // power state of the core
    typedef enum logic [1:0] {
        IPM_RUN   = 2'b00,
        IPM_IDLE  = 2'b01,
        IPM_PDOWN = 2'b10,
        IPM_WAKE  = 2'b11
    } ipm_mode_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ipm_bus_t;

    // complete block state
    typedef struct packed {
        logic [7:0]  ien_first;
        logic [7:0]  ien_second;
        logic [7:0]  prio_lo_a;
        logic [7:0]  prio_hi_a;
        logic [7:0]  prio_lo_b;
        logic [7:0]  prio_hi_b;
        logic [7:0]  rdata;
        ipm_mode_t   mode;
        logic [10:0] hold_cnt;
        logic [1:0]  ext0_sync;
        logic [1:0]  ext1_sync;
        logic        req_valid;
        logic [2:0]  req_src;
        logic [1:0]  req_level;
        logic        pc_stop;
        logic        clk_stop;
        logic        addr_latch;
        logic        fetch_strobe;
    } ipm_state_t;
endpackage : ipm_pkg

// ==== verilog/ipm_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ipm_defs.svh"

module ipm_ctrl
    import ipm_pkg::*;
#(
    parameter int WAKE_HOLD = `IPM_WAKE_HOLD_CYC  // minimum low time of wake input
) (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output var  logic [7:0] rdata_out,
    // interrupt sources, one bit per source in polling order
    input  wire logic [7:0] irq_req_in,
    // external pins, active low, level sensitive
    input  wire logic       ext0_n_in,
    input  wire logic       ext1_n_in,
    // current service level from the core, 3'h4 means none active
    input  wire logic [2:0] active_level_in,
    // interrupt acknowledge from the core when service starts
    input  wire logic       irq_ack_in,
    // towards the core
    output var  logic       req_valid_out,
    output var  logic [2:0] req_src_out,
    output var  logic [1:0] req_level_out,
    output var  logic       pc_stop_out,
    output var  logic       clk_stop_out,
    output var  logic       addr_latch_out,
    output var  logic       fetch_strobe_out
);

    // all state lives in one packed struct: one always_comb builds the copy
    // and one always_ff registers it, so every output leaves a flip-flop
    ipm_state_t st;       // registered state
    ipm_state_t next_st;  // next state

    // decoded views of the registers and input pins, rebuilt every cycle
    ipm_bus_t   bus;      // gathered bus request
    logic [7:0] enables;  // per source enable in polling order
    logic [7:0] prio_lo;  // per source low priority bit in polling order
    logic [7:0] prio_hi;  // per source high priority bit in polling order
    logic [1:0] level [8];  // per source two-bit level, high bit over low bit
    logic [7:0] pending;  // enabled and requesting
    logic [7:0] pwr_rd;   // power control read value

    // gather the loose bus pins into one carrier so the decode reads one name
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // map register bits to polling order: ext0 brownout t0 ext1 t1 pca serial t2
    // the enable and priority registers keep their own bit layout, which is not
    // the polling order; reordering once here lets the arbiter index by position
    // and keeps every later loop free of per-source special cases
    always_comb begin
        enables = {st.ien_first[5], st.ien_first[4], st.ien_first[6], st.ien_first[3],
                   st.ien_first[2], st.ien_first[1], st.ien_second[`IPM_BIT_BROWNOUT_EN],
                   st.ien_first[0]};
        prio_lo = {st.prio_lo_a[5], st.prio_lo_a[4], st.prio_lo_a[6], st.prio_lo_a[3],
                   st.prio_lo_a[2], st.prio_lo_a[1], st.prio_lo_b[`IPM_BIT_BROWNOUT_PR],
                   st.prio_lo_a[0]};
        prio_hi = {st.prio_hi_a[5], st.prio_hi_a[4], st.prio_hi_a[6], st.prio_hi_a[3],
                   st.prio_hi_a[2], st.prio_hi_a[1], st.prio_hi_b[`IPM_BIT_BROWNOUT_PR],
                   st.prio_hi_a[0]};
    end

    // per source level and pending flag
    // a source competes only when its own enable and the global enable are set;
    // the request inputs come from logic on this clock, so they are not synchronised
    // and a request seen here is offered on the very next edge
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_src
            assign level[g]   = {prio_hi[g], prio_lo[g]};
            assign pending[g] = irq_req_in[g] & enables[g]
                                & st.ien_first[`IPM_BIT_GLOBAL_EN];
        end
    endgenerate

    // power control reads back the request bits from the current mode;
    // in the wake state neither bit reads set, the core is stopped then anyway
    assign pwr_rd = {6'h00, st.mode == IPM_PDOWN, st.mode == IPM_IDLE};

    // next state: bus writes, arbitration and power sequencing
    // every field starts from its registered value, so a branch that leaves a
    // field alone holds it; only rdata and req_valid are cleared on each pass
    always_comb begin
        logic       found;
        logic [1:0] best_lvl;
        logic [2:0] best_src;
        logic       ext0_low;
        logic       ext1_low;
        logic       wake_ok;
        found    = 1'b0;
        best_lvl = 2'h0;
        best_src = 3'h0;
        // start from the held state; every branch below only overrides fields
        next_st  = st;
        // second flop is the only reader of the first
        // the pins come from outside this clock, so only the second stage is
        // trusted; the first may still be settling when it is captured
        next_st.ext0_sync = {st.ext0_sync[0], ext0_n_in};
        next_st.ext1_sync = {st.ext1_sync[0], ext1_n_in};
        ext0_low = ~st.ext0_sync[1];
        ext1_low = ~st.ext1_sync[1];
        // highest level wins, earlier polling position breaks ties
        // the strict greater-than keeps the first source found at a level, which
        // is the lower index and therefore the earlier one in the polling order
        for (int i = 0; i < 8; i++) begin
            if (pending[i] && (!found || level[i] > best_lvl)) begin
                found    = 1'b1;
                best_lvl = level[i];
                best_src = 3'(i);
            end
        end
        // only a strictly higher level than the one in service may preempt
        // an equal level waits for the running routine to finish, so a source can
        // never interrupt its own service routine
        if (found && {1'b0, best_lvl} <= active_level_in && active_level_in != 3'h4) begin
            found = 1'b0;
        end
        // register writes, reserved bits stay zero
        // masking here instead of trusting software keeps readback clean even when
        // a program ignores the reserved bits; the power control port is handled below
        if (bus.wr) begin
            case (bus.addr)
                `IPM_OFS_IEN_FIRST:  next_st.ien_first  = bus.wdata;
                `IPM_OFS_IEN_SECOND: next_st.ien_second = bus.wdata & `IPM_MASK_SECOND;
                `IPM_OFS_PRIO_LO_A:  next_st.prio_lo_a  = bus.wdata & `IPM_MASK_PRIO_A;
                `IPM_OFS_PRIO_HI_A:  next_st.prio_hi_a  = bus.wdata & `IPM_MASK_PRIO_A;
                `IPM_OFS_PRIO_LO_B:  next_st.prio_lo_b  = bus.wdata & `IPM_MASK_PRIO_B;
                `IPM_OFS_PRIO_HI_B:  next_st.prio_hi_b  = bus.wdata & `IPM_MASK_PRIO_B;
                default: ;
            endcase
        end
        // read data, one cycle later; unmapped reads give zero
        // rdata falls back to zero every cycle, so a value stands for exactly the
        // cycle after the read strobe and the port can be or-ed with other readers
        next_st.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `IPM_OFS_IEN_FIRST:  next_st.rdata = st.ien_first;
                `IPM_OFS_IEN_SECOND: next_st.rdata = st.ien_second;
                `IPM_OFS_PRIO_LO_A:  next_st.rdata = st.prio_lo_a;
                `IPM_OFS_PRIO_HI_A:  next_st.rdata = st.prio_hi_a;
                `IPM_OFS_PRIO_LO_B:  next_st.rdata = st.prio_lo_b;
                `IPM_OFS_PRIO_HI_B:  next_st.rdata = st.prio_hi_b;
                `IPM_OFS_PWR_CTRL:   next_st.rdata = pwr_rd;
                `IPM_OFS_STATUS:     next_st.rdata = {3'h0, st.req_valid, 1'b0, st.req_src};
                default:             next_st.rdata = 8'h00;
            endcase
        end
        // wake allowed only from enabled, low external pins
        // only the synchronised level is used: edge mode is not modelled, so a
        // short glitch on a pin can start a wake that later falls back to power-down
        wake_ok = st.ien_first[`IPM_BIT_GLOBAL_EN]
                  & ((ext0_low & enables[0]) | (ext1_low & enables[3]));
        // requests are offered in run and idle and on the exit from wake; power-down leaves this low
        next_st.req_valid = 1'b0;
        case (st.mode)
            IPM_RUN: begin
                // the winner is offered each cycle and dropped as soon as it is gone;
                // the core takes it with irq_ack_in while it stands
                next_st.req_valid = found;
                next_st.req_src   = best_src;
                next_st.req_level = best_lvl;
                // power-down takes precedence if both bits are written
                // writes to the power control port outside run are dropped: the core
                // is stopped then, and a second request could skip the wake sequence
                if (bus.wr && bus.addr == `IPM_OFS_PWR_CTRL) begin
                    if (bus.wdata[`IPM_BIT_PDOWN]) begin
                        next_st.mode = IPM_PDOWN;
                    end else if (bus.wdata[`IPM_BIT_IDLE]) begin
                        next_st.mode = IPM_IDLE;
                    end
                end
            end
            IPM_IDLE: begin
                // sources keep running, any enabled request is offered
                // the clock still runs in idle, so the arbiter works exactly as in run
                next_st.req_valid = found;
                next_st.req_src   = best_src;
                next_st.req_level = best_lvl;
                // the start of service clears the idle request; the core resumes
                // at the instruction after the one that entered idle
                if (irq_ack_in && st.req_valid) begin
                    next_st.mode = IPM_RUN;
                end
            end
            IPM_PDOWN: begin
                // nothing but the wake pins is looked at
                // the request inputs are ignored here, whatever their enables
                next_st.hold_cnt = 11'h000;
                if (wake_ok) begin
                    next_st.mode = IPM_WAKE;
                    // req_valid stays low here, so req_src is free to remember the
                    // pin that started the wake; ext0 wins when both pins are low
                    next_st.req_src = (ext0_low & enables[0]) ? 3'h0 : 3'h3;
                end
            end
            IPM_WAKE: begin
                // the oscillator is restarting, count the low time
                // the counter saturates at the hold time, so a pin held low far longer
                // than needed cannot wrap and make the exit look early
                if (!wake_ok) begin
                    if (st.hold_cnt >= 11'(WAKE_HOLD)) begin
                        // pin back high after full hold: start the service
                        next_st.mode      = IPM_RUN;
                        // the offer stands one cycle; run recomputes it on the next edge
                        next_st.req_valid = 1'b1;
                        // serve the pin that started the wake, not merely the first
                        // enabled one; by now the enabled pins are back high
                        next_st.req_src   = st.req_src;
                        next_st.req_level = level[st.req_src];
                    end else begin
                        // released too early: the oscillator may not be stable, so
                        // the exit is abandoned and power-down is entered again
                        next_st.mode = IPM_PDOWN;
                    end
                end else if (st.hold_cnt < 11'(WAKE_HOLD)) begin
                    // still low: count one more cycle of the hold
                    next_st.hold_cnt = st.hold_cnt + 11'h001;
                end
            end
            default: next_st.mode = IPM_RUN; // an unused code falls back to run
        endcase
        // an offer made on the edge that enters power-down would stand beside a
        // stopped clock with nobody to take it, so it is withdrawn at once
        if (next_st.mode == IPM_PDOWN) begin
            next_st.req_valid = 1'b0;
        end
        // outputs follow the next mode so they stay in step with it
        // computing them from the next mode costs a little logic but saves a cycle
        // of strobes that would otherwise disagree with the mode they describe
        next_st.pc_stop      = next_st.mode != IPM_RUN;
        next_st.clk_stop     = next_st.mode == IPM_PDOWN;
        next_st.addr_latch   = next_st.mode != IPM_PDOWN && next_st.mode != IPM_WAKE;
        next_st.fetch_strobe = next_st.addr_latch;
    end

    // state register; reset puts every field to its power-on value
    // reset is synchronous and wins in every mode, so a reset in idle or power-down
    // returns the block to run exactly as at power-on; the synchronisers reset high
    // to match the idle level of the pins and avoid a false wake after reset
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st              <= '0;
            st.mode         <= IPM_RUN;
            st.ext0_sync    <= 2'h3;
            st.ext1_sync    <= 2'h3;
            // both strobes idle high, as in run
            st.addr_latch   <= 1'b1;
            st.fetch_strobe <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    // no logic sits between the flip-flops and the pins, so output timing is fixed
    assign rdata_out        = st.rdata;
    assign req_valid_out    = st.req_valid;
    assign req_src_out      = st.req_src;
    assign req_level_out    = st.req_level;
    assign pc_stop_out      = st.pc_stop;
    assign clk_stop_out     = st.clk_stop;
    assign addr_latch_out   = st.addr_latch;
    assign fetch_strobe_out = st.fetch_strobe;

endmodule : ipm_ctrl
`default_nettype wire

// ==== bench/ipm_ctrl_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module ipm_ctrl_sva #(
    parameter int WAKE_HOLD = 1024
) (
    // clock and reset
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic [7:0] rdata_out,
    // core side
    input wire logic       irq_ack_in,
    input wire logic       req_valid_out,
    input wire logic [2:0] req_src_out,
    input wire logic       pc_stop_out,
    input wire logic       clk_stop_out,
    input wire logic       addr_latch_out,
    input wire logic       fetch_strobe_out
);
    logic [11:0] wake_cnt; // cycles spent waking
    logic        glob_en;  // shadow of the global enable
    wire         wake_st = pc_stop_out && !clk_stop_out && !addr_latch_out;
    wire         pwr_wr = wr_in && addr_in == 8'h87;
    // shadows follow the port, so no internal state is peeked at
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wake_cnt <= 12'h000;
            glob_en  <= 1'b0;
        end else begin
            wake_cnt <= wake_st ? wake_cnt + 12'h001 : 12'h000;
            glob_en  <= (wr_in && addr_in == 8'ha8) ? wdata_in[7] : glob_en;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // wake state left towards run
    sequence s_wake_exit;
        $fell(pc_stop_out) && $past(wake_st);
    endsequence
    AST_PD_ENTRY: assert property (pwr_wr && wdata_in == 8'h02 && !pc_stop_out
        |=> pc_stop_out && clk_stop_out) else $error("power-down not entered");
    AST_IDLE_ENTRY: assert property (pwr_wr && wdata_in == 8'h01 && !pc_stop_out
        |=> pc_stop_out && !clk_stop_out && addr_latch_out && fetch_strobe_out)
        else $error("idle not entered");
    AST_PD_STROBES: assert property (clk_stop_out |-> !addr_latch_out && !fetch_strobe_out)
        else $error("strobes not low in power-down");
    AST_PD_IGNORE: assert property (clk_stop_out |-> !req_valid_out)
        else $error("request offered in power-down");
    AST_IDLE_EXIT: assert property (pc_stop_out && addr_latch_out && req_valid_out && irq_ack_in
        |=> !pc_stop_out) else $error("idle kept after acknowledge");
    AST_WAKE_HOLD: assert property (s_wake_exit |-> wake_cnt >= WAKE_HOLD - 1)
        else $error("wake completed too early");
    AST_WAKE_SVC: assert property (s_wake_exit |-> ##[0:2] (req_valid_out
        && (req_src_out == 3'h0 || req_src_out == 3'h3))) else $error("no service after wake");
    AST_GLOBAL_EN: assert property (req_valid_out |-> glob_en || $past(glob_en))
        else $error("request offered with global enable off");
    AST_RESET: assert property (disable iff (1'b0) rst_in |=> !pc_stop_out && !clk_stop_out
        && addr_latch_out && fetch_strobe_out && !req_valid_out && rdata_out == 8'h00)
        else $error("reset state wrong");
endmodule : ipm_ctrl_sva
bind ipm_ctrl ipm_ctrl_sva #(.WAKE_HOLD(WAKE_HOLD)) u_sva (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rdata_out(rdata_out), .irq_ack_in(irq_ack_in),
    .req_valid_out(req_valid_out), .req_src_out(req_src_out), .pc_stop_out(pc_stop_out),
    .clk_stop_out(clk_stop_out), .addr_latch_out(addr_latch_out),
    .fetch_strobe_out(fetch_strobe_out));
`default_nettype wire

// ==== bench/ipm_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ipm_core_model (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic       ack_en_in,
    input  wire logic [2:0] svc_level_in,
    input  wire logic       req_valid_in,
    output var  logic       irq_ack_out,
    output var  logic [2:0] active_level_out
);
    // level of the routine the core is running, 3'h4 when none is in service
    assign active_level_out = svc_level_in;
    // acknowledge an offer one cycle late; ack_en_in low makes it stall
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            irq_ack_out <= 1'b0;
        end else begin
            irq_ack_out <= ack_en_in && req_valid_in && !irq_ack_out;
        end
    end
endmodule : ipm_core_model
`default_nettype wire

// ==== bench/irq_priority_and_power_modes_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module irq_priority_and_power_modes_tb;
    localparam int HOLD = 8; // short wake hold keeps the run brief
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr_s = 1'b0;
    logic       rd_s = 1'b0;
    logic [7:0] irq = 8'h00;
    logic       ext0_n = 1'b1;
    logic       ext1_n = 1'b1;
    logic       ack_en = 1'b0;
    logic [2:0] svc = 3'h4; // level the core reports in service, 3'h4 for none
    logic [7:0] rdata;
    logic       vld, pc_stop, clk_stop, al, fs, ack;
    logic [2:0] src, act;
    logic [1:0] lvl;
    int         errors = 0;
    int         n_tests = 0;
    wire  [7:0] req_w = {2'b00, vld, lvl, src};
    wire  [7:0] mode_w = {4'h0, pc_stop, clk_stop, al, fs};
    always #50 clk = ~clk;
    ipm_ctrl #(.WAKE_HOLD(HOLD)) uut (
        .clk_sys_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
        .rd_in(rd_s), .rdata_out(rdata), .irq_req_in(irq), .ext0_n_in(ext0_n),
        .ext1_n_in(ext1_n), .active_level_in(act), .irq_ack_in(ack), .req_valid_out(vld),
        .req_src_out(src), .req_level_out(lvl), .pc_stop_out(pc_stop),
        .clk_stop_out(clk_stop), .addr_latch_out(al), .fetch_strobe_out(fs));
    ipm_core_model u_core (
        .clk_sys_in(clk), .rst_in(rst), .ack_en_in(ack_en), .req_valid_in(vld),
        .svc_level_in(svc), .irq_ack_out(ack), .active_level_out(act));
    task automatic wrap_up();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(exp, rdata);
    endtask : rd
    // pins pass two sync flops, so give state time to land
    task automatic settle();
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic wait_run();
        int i;
        for (i = 0; i < 100 && pc_stop !== 1'b0; i++) @(negedge clk);
        if (i == 100) begin
            errors++;
            wrap_up();
        end
    endtask : wait_run
    task automatic t_regs();
        logic [7:0] ofs [5] = '{8'hb7, 8'hb8, 8'he8, 8'hf7, 8'hf8};
        logic [7:0] msk [5] = '{8'h7f, 8'h7f, 8'h08, 8'h10, 8'h10};
        for (int i = 0; i < 5; i++) rd(ofs[i], 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 8'hff);
            rd(ofs[i], msk[i]);
        end
        rd(8'h00, 8'h00);
        for (int i = 0; i < 5; i++) wr(ofs[i], 8'h00);
    endtask : t_regs
    task automatic t_arb();
        wr(8'ha8, 8'hff);
        wr(8'he8, 8'h08);
        irq <= 8'hff;
        settle();
        chk(8'h20, req_w);
        wr(8'hb8, 8'h20);
        settle();
        chk(8'h2f, req_w);
        rd(8'h90, 8'h17);
        wr(8'hf7, 8'h10);
        settle();
        chk(8'h31, req_w);
        wr(8'hf8, 8'h10);
        settle();
        chk(8'h39, req_w);
        wr(8'he8, 8'h00);
        settle();
        chk(8'h2f, req_w);
        @(posedge clk);
        svc <= 3'h1;
        settle();
        chk(8'h0f, req_w);
        @(posedge clk);
        svc <= 3'h0;
        settle();
        chk(8'h2f, req_w);
        @(posedge clk);
        svc <= 3'h4;
        wr(8'ha8, 8'h7f);
        settle();
        chk(8'h00, req_w);
    endtask : t_arb
    task automatic t_idle();
        @(posedge clk);
        irq <= 8'h00;
        wr(8'ha8, 8'h82);
        wr(8'h87, 8'h01);
        settle();
        chk(8'h0b, mode_w);
        rd(8'h87, 8'h01);
        @(posedge clk);
        ack_en <= 1'b1;
        irq <= 8'h04;
        wait_run();
        settle();
        chk(8'h03, mode_w);
        @(posedge clk);
        ack_en <= 1'b0;
        irq <= 8'h00;
    endtask : t_idle
    task automatic t_pdown();
        wr(8'ha8, 8'h85);
        wr(8'h87, 8'h02);
        irq <= 8'hff;
        settle();
        chk(8'h0c, mode_w);
        rd(8'h87, 8'h02);
        @(posedge clk);
        ext1_n <= 1'b0;
        repeat (HOLD / 2) @(posedge clk);
        ext1_n <= 1'b1;
        settle();
        chk(8'h0c, mode_w);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk(8'h03, mode_w);
        rd(8'ha8, 8'h00);
    endtask : t_pdown
    task automatic t_wake();
        @(posedge clk);
        irq <= 8'h00;
        wr(8'ha8, 8'h81);
        wr(8'h87, 8'h02);
        ext0_n <= 1'b0;
        repeat (HOLD * 2) @(posedge clk);
        ext0_n <= 1'b1;
        wait_run();
        settle();
        chk(8'h03, mode_w);
        rd(8'h87, 8'h00);
    endtask : t_wake
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_arb();
        t_idle();
        t_pdown();
        t_wake();
        wrap_up();
    end
endmodule : irq_priority_and_power_modes_tb
`default_nettype wire
